// *** verilog/pis_pkg.sv ***
// Package: constants and carrier types for the power-up init sequencer
package pis_pkg;

  // Reference clock period in ns (25 MHz)
  localparam int unsigned PIS_CLK_NS        = 40;
  // Least PLL settle wait after reset release, in us
  localparam int unsigned PIS_PLL_WAIT_US   = 100;
  localparam int unsigned PIS_PLL_WAIT_CYC  =
    (PIS_PLL_WAIT_US * 1000 + PIS_CLK_NS - 1) / PIS_CLK_NS;
  // Flash serial clock: nominal 33.3 MHz; from 25 MHz the closest legal
  // division is one half period per reference clock cycle
  localparam int unsigned PIS_SCK_HALF_CYC  = 1;
  // Flash read command and framing
  localparam logic [7:0]  PIS_FAST_READ_OP  = 8'h0b;
  localparam logic [23:0] PIS_CFG_ADDR      = 24'h000000;
  localparam int unsigned PIS_ADDR_BYTES    = 3;
  localparam int unsigned PIS_DUMMY_BYTES   = 1;
  // Header bytes sent before data: opcode, address, dummy
  localparam logic [5:0]  PIS_HDR_BITS      = 6'h28;
  // Configuration bytes read from flash
  localparam logic [15:0] PIS_CFG_BYTES     = 16'h0040;

  typedef enum logic [2:0] {
    PIS_RESET_HOLD,
    PIS_PLL_LOCK,
    PIS_FLASH_LOAD,
    PIS_DONE
  } pis_state_t;

  // Flash pin group: outputs plus their enables
  typedef struct packed {
    logic sck;
    logic sck_oe;
    logic mosi;
    logic mosi_oe;
    logic cs_n;
    logic cs_n_oe;
  } pis_flash_t;

  // Config byte writeback to the rest of the controller
  typedef struct packed {
    logic        valid;
    logic [15:0] index;
    logic [7:0]  data;
  } pis_cfg_t;

endpackage : pis_pkg

// *** verilog/pis_flash_reader.sv ***
// Single-lane SPI mode 0 fast-read engine for the configuration flash
`timescale 1ns/1ps
module pis_flash_reader
  import pis_pkg::*;
(
  input  wire logic       ref_clk,
  input  wire logic       sys_rst,
  input  wire logic       start,
  input  wire logic       miso,
  output pis_flash_t      pins,
  output pis_cfg_t        cfg,
  output logic            done
);

  logic [39:0] hdr_q;
  logic [5:0]  hdr_cnt_q;
  logic [15:0] byte_cnt_q;
  logic [2:0]  bit_cnt_q;
  logic [7:0]  shift_q;
  logic        busy_q;
  logic        go_q;
  logic        sck_q;
  logic        take_q;
  logic        sck_d;
  logic        hdr_step;
  logic        last_bit;

  // The pin stage lags one cycle, so returned data is taken one cycle
  // after the internal fall, when the pin itself falls
  assign hdr_step = busy_q && sck_q && (hdr_cnt_q != PIS_HDR_BITS);
  assign last_bit = take_q && (bit_cnt_q == 3'h7) &&
                    (byte_cnt_q == PIS_CFG_BYTES - 16'h0001);
  // One idle cycle after select falls gives the first bit its setup
  assign sck_d    = (busy_q && go_q && !last_bit) ? ~sck_q : 1'b0;

  // Serial clock: idle low, toggles each reference cycle while busy
  always_ff @(posedge ref_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      sck_q <= 1'b0;
      go_q  <= 1'b0;
    end
    else
    begin
      sck_q <= sck_d; // RL12
      go_q  <= busy_q;
    end
  end

  // Header shift on the falling serial edge, capture at the pin's fall
  always_ff @(posedge ref_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      busy_q     <= 1'b0;
      hdr_q      <= 40'h0000000000;
      hdr_cnt_q  <= 6'h00;
      byte_cnt_q <= 16'h0000;
      bit_cnt_q  <= 3'h0;
      shift_q    <= 8'h00;
      take_q     <= 1'b0;
      done       <= 1'b0;
      cfg        <= '0;
    end
    else
    begin
      cfg.valid <= 1'b0;
      take_q    <= busy_q && sck_q && (hdr_cnt_q == PIS_HDR_BITS);
      if (start && !busy_q && !done)
      begin
        busy_q <= 1'b1;
        hdr_q  <= {PIS_FAST_READ_OP, PIS_CFG_ADDR, 8'h00}; // RL11
        hdr_cnt_q  <= 6'h00;
        byte_cnt_q <= 16'h0000;
        bit_cnt_q  <= 3'h0;
      end
      else if (hdr_step)
      begin
        // Internal fall: shift the header for the next launch
        hdr_q     <= {hdr_q[38:0], 1'b0}; // RL13
        hdr_cnt_q <= hdr_cnt_q + 6'h01;
      end
      else if (take_q)
      begin
        // Pin falls now: the flash bit has stood for a whole cycle
        shift_q   <= {shift_q[6:0], miso}; // RL13
        bit_cnt_q <= bit_cnt_q + 3'h1;
        if (bit_cnt_q == 3'h7)
        begin
          cfg.valid  <= 1'b1;
          cfg.index  <= byte_cnt_q;
          cfg.data   <= {shift_q[6:0], miso};
          byte_cnt_q <= byte_cnt_q + 16'h0001;
          if (last_bit)
          begin
            busy_q <= 1'b0;
            done   <= 1'b1;
          end
        end
      end
    end
  end

  // Pins tri-stated by the reset path; the top registers the enables again
  always_ff @(posedge ref_clk or posedge sys_rst)
  begin
    if (sys_rst)
      pins <= '{sck: 1'b0, sck_oe: 1'b0, mosi: 1'b0, mosi_oe: 1'b0,
                cs_n: 1'b1, cs_n_oe: 1'b0};
    else
    begin
      pins.sck     <= sck_d;
      pins.sck_oe  <= 1'b1;
      pins.mosi    <= hdr_step ? hdr_q[38] : hdr_q[39]; // RL13
      pins.mosi_oe <= 1'b1;
      pins.cs_n    <= ~busy_q;
      pins.cs_n_oe <= 1'b1;
    end
  end

endmodule : pis_flash_reader

// *** verilog/pis_powerup_init_sequencer.sv ***
// Top: power-up reset, PLL wait and flash self-configuration sequencer
// Operation
// RL1: Power monitor holds reset low during power-up.
// RL2: Reset held until supplies good, power-good high, clocks stable.
// RL3: In reset, outputs inactive and bidirectional pins set as inputs.
// RL4: In reset, mirror power, LED and flash pins float.
// RL5: After reset, lock PLL first, then load configuration from flash.
// RL6: On reset release, all pins become active.
// RL7: Init-busy goes high right after reset release.
// RL8: Init-busy goes low when initialization completes.
// RL9: Host may send I2C commands after busy low or 100 ms.
// RL10: Host timeout starts at reset release; busy ignored in reset.
// RL11: Flash read uses only opcode 0x0b, three address, one dummy byte.
// RL12: Single SPI mode 0 flash interface, serial clock near 33.3 MHz; the code runs it at 12.5 MHz.
// RL13: Launch and sample flash data on falling serial clock edge.
// RL14: Clock and reset kept 500 us after power-good falls.
`timescale 1ns/1ps
module pis_powerup_init_sequencer
  import pis_pkg::*;
(
  input  wire logic ref_clk,
  input  wire logic sys_rst,
  input  wire logic pll_locked,
  input  wire logic flash_serial_in,
  input  wire logic gpio_in,
  output logic      init_busy_out,
  output logic      gpio_out,
  output logic      gpio_oe,
  output logic      mirror_power_enable,
  output logic      mirror_power_enable_oe,
  output logic      led_driver_on,
  output logic      led_driver_on_oe,
  output logic      led_select_0,
  output logic      led_select_0_oe,
  output logic      led_select_1,
  output logic      led_select_1_oe,
  output logic      flash_serial_clock,
  output logic      flash_serial_clock_oe,
  output logic      flash_serial_out,
  output logic      flash_serial_out_oe,
  output logic      flash_chip_select,
  output logic      flash_chip_select_oe,
  output logic      cfg_valid,
  output logic [15:0] cfg_index,
  output logic [7:0]  cfg_data
);

  pis_state_t  state_q;
  logic [11:0] wait_q;
  logic        rd_start;
  logic        rd_done;
  pis_flash_t  fpins;
  pis_cfg_t    fcfg;

  assign rd_start = (state_q == PIS_FLASH_LOAD);

  pis_flash_reader u_reader (
    .ref_clk (ref_clk),
    .sys_rst (sys_rst),
    .start   (rd_start),
    .miso    (flash_serial_in),
    .pins    (fpins),
    .cfg     (fcfg),
    .done    (rd_done)
  );

  // Sequence: PLL wait with lock, then flash load, then done
  always_ff @(posedge ref_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      state_q <= PIS_RESET_HOLD;
      wait_q  <= 12'h000;
    end
    else
    begin
      unique case (state_q)
        PIS_RESET_HOLD:
          state_q <= PIS_PLL_LOCK;
        PIS_PLL_LOCK:
        begin
          // Lock seen only after the least settle time, so a glitchy
          // early lock indication cannot start the flash load
          if (wait_q != 12'(PIS_PLL_WAIT_CYC))
            wait_q <= wait_q + 12'h001;
          else if (pll_locked)
            state_q <= PIS_FLASH_LOAD; // RL5
        end
        PIS_FLASH_LOAD:
          if (rd_done)
            state_q <= PIS_DONE; // RL5
        PIS_DONE:
          state_q <= PIS_DONE;
        default:
          state_q <= PIS_RESET_HOLD;
      endcase
    end
  end

  // Busy flag: low in reset, high from first edge, low at completion
  always_ff @(posedge ref_clk or posedge sys_rst)
  begin
    if (sys_rst)
      init_busy_out <= 1'b0; // RL3
    else
      init_busy_out <= (state_q != PIS_DONE); // RL7 RL8
  end

  // Pin enables: floated or inputs in reset, all active after release
  always_ff @(posedge ref_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      gpio_out               <= 1'b0;
      gpio_oe                <= 1'b0; // RL3
      mirror_power_enable    <= 1'b0;
      mirror_power_enable_oe <= 1'b0; // RL4
      led_driver_on          <= 1'b0;
      led_driver_on_oe       <= 1'b0; // RL4
      led_select_0           <= 1'b0;
      led_select_0_oe        <= 1'b0; // RL4
      led_select_1           <= 1'b0;
      led_select_1_oe        <= 1'b0; // RL4
    end
    else
    begin
      gpio_out               <= gpio_in;
      gpio_oe                <= 1'b1; // RL6
      mirror_power_enable    <= (state_q == PIS_DONE);
      mirror_power_enable_oe <= 1'b1; // RL6
      led_driver_on          <= 1'b0;
      led_driver_on_oe       <= 1'b1; // RL6
      led_select_0           <= 1'b0;
      led_select_0_oe        <= 1'b1; // RL6
      led_select_1           <= 1'b0;
      led_select_1_oe        <= 1'b1; // RL6
    end
  end

  // Flash pins: one more register stage keeps outputs flop-driven
  always_ff @(posedge ref_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      flash_serial_clock    <= 1'b0;
      flash_serial_clock_oe <= 1'b0; // RL4
      flash_serial_out      <= 1'b0;
      flash_serial_out_oe   <= 1'b0; // RL4
      flash_chip_select     <= 1'b1;
      flash_chip_select_oe  <= 1'b0; // RL4
      cfg_valid             <= 1'b0;
      cfg_index             <= 16'h0000;
      cfg_data              <= 8'h00;
    end
    else
    begin
      flash_serial_clock    <= fpins.sck;
      flash_serial_clock_oe <= fpins.sck_oe; // RL6
      flash_serial_out      <= fpins.mosi; // RL13
      flash_serial_out_oe   <= fpins.mosi_oe;
      flash_chip_select     <= fpins.cs_n;
      flash_chip_select_oe  <= fpins.cs_n_oe;
      cfg_valid             <= fcfg.valid;
      cfg_index             <= fcfg.index;
      cfg_data              <= fcfg.data;
    end
  end

endmodule : pis_powerup_init_sequencer

// *** verification/pis_flash_model.sv ***
// Behavioural serial flash answering the fast read
`timescale 1ns/1ps
module pis_flash_model
(
  input  wire logic       sck,
  input  wire logic       cs_n,
  input  wire logic       mosi,
  input  wire logic [7:0] seed,
  output logic            miso,
  output logic [39:0]     hdr
);
  int         bits;
  logic [7:0] b;
  initial miso = 1'b0;
  always @(negedge cs_n) bits = 0;
  always @(posedge sck)
    if (!cs_n)
    begin
      if (bits < 40) hdr = {hdr[38:0], mosi};
      bits = bits + 1;
    end
  // Released line shows the inverse, never a stale valid bit
  always @(negedge sck or posedge cs_n)
    if (cs_n) miso = ~miso;
    else if (bits >= 40)
    begin
      b = seed ^ 8'((bits - 40) / 8);
      miso = b[7 - ((bits - 40) % 8)];
    end
endmodule : pis_flash_model

// *** verification/pis_checker_asserts.sv ***
// Assertions on the init sequencer ports
`timescale 1ns/1ps
module pis_checker
(
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic pll_locked,
  input wire logic init_busy_out,
  input wire logic gpio_oe,
  input wire logic mirror_power_enable_oe,
  input wire logic led_driver_on_oe,
  input wire logic flash_serial_clock,
  input wire logic flash_serial_clock_oe,
  input wire logic flash_serial_out,
  input wire logic flash_chip_select,
  input wire logic cfg_valid
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  logic [11:0] cyc_q;
  // Saturates so a long idle run cannot wrap
  always_ff @(posedge ref_clk or posedge sys_rst)
    if (sys_rst) cyc_q <= 12'h000;
    else if (cyc_q != 12'hfff) cyc_q <= cyc_q + 12'h001;
  sequence s_rel;
    $fell(sys_rst);
  endsequence
  sequence s_cs_go;
    $fell(flash_chip_select);
  endsequence
  AST_FLOAT_IN_RST:
    assert property (s_rel |-> $past(!(mirror_power_enable_oe |
      led_driver_on_oe | flash_serial_clock_oe | gpio_oe)))
    else $error("pin driven in reset");
  AST_BUSY_UP:
    assert property (s_rel |=> init_busy_out[*3]) else $error("no busy");
  AST_PINS_LIVE:
    assert property (s_rel |-> ##2 gpio_oe && mirror_power_enable_oe &&
      flash_serial_clock_oe) else $error("pins idle");
  AST_LOCK_FIRST:
    assert property (s_cs_go |-> pll_locked && init_busy_out &&
      cyc_q >= 12'h9c4) else $error("flash before lock");
  AST_SCK_IDLE:
    assert property (flash_chip_select |-> !flash_serial_clock)
    else $error("clock not idle low");
  AST_LAUNCH_FALL:
    assert property (!flash_chip_select && $changed(flash_serial_out)
      |-> !flash_serial_clock) else $error("launch on rise");
  AST_DONE:
    assert property ($fell(init_busy_out) |-> flash_chip_select ##1
      !init_busy_out[*8]) else $error("bad done");
  AST_CFG_PULSE:
    assert property (cfg_valid |=> !cfg_valid[*4]) else $error("long pulse");
endmodule : pis_checker
bind pis_powerup_init_sequencer pis_checker i_pis_checker (.*);

// *** verification/testbench.sv ***
// Self-checking bench for the power-up init sequencer
`timescale 1ns/1ps
module testbench;
  import pis_pkg::*;
  logic ref_clk = 1'b0, sys_rst = 1'b1, pll_locked = 1'b0, gpio_in = 1'b0;
  logic [7:0]  seed = 8'h00, lfsr = 8'h18;
  logic [39:0] hdr;
  logic [15:0] cfg_index;
  logic [7:0]  cfg_data;
  logic init_busy_out, gpio_out, gpio_oe, mirror_power_enable,
    mirror_power_enable_oe, led_driver_on, led_driver_on_oe, led_select_0,
    led_select_0_oe, led_select_1, led_select_1_oe, flash_serial_clock,
    flash_serial_clock_oe, flash_serial_out, flash_serial_out_oe,
    flash_chip_select, flash_chip_select_oe, cfg_valid, flash_serial_in;
  int error_cnt = 0, comparisons = 0, cyc = 0, nbytes = 0;
  pis_powerup_init_sequencer i_pis_powerup_init_sequencer (.*);
  pis_flash_model i_pis_flash_model (.sck(flash_serial_clock),
    .cs_n(flash_chip_select), .mosi(flash_serial_out), .seed(seed),
    .miso(flash_serial_in), .hdr(hdr));
  function automatic logic [7:0] lfsr_next(input logic [7:0] v);
    return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
  endfunction : lfsr_next
  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("BAD %0t seen %h want %h", $time, seen, exp);
    end
  endtask : check
  task automatic report_and_stop;
    $display("errors %0d comparisons %0d", error_cnt, comparisons);
    if (error_cnt == 0 && comparisons > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : report_and_stop
  initial forever #20 ref_clk = ~ref_clk;
  always @(posedge ref_clk)
  begin
    cyc++;
    if (cyc == 40000)
    begin
      error_cnt++;
      report_and_stop();
    end
    else if (cfg_valid === 1'b1)
    begin
      check(cfg_index, nbytes);
      check(cfg_data, seed ^ 8'(nbytes));
      nbytes++;
    end
  end
  // Run 1 locks late, run 2 is cut by reset in mid load
  initial
  begin
    for (int run = 0; run < 4; run++)
    begin
      lfsr = lfsr_next(lfsr);
      @(posedge ref_clk);
      sys_rst <= 1'b1;
      pll_locked <= 1'b0;
      seed <= lfsr;
      gpio_in <= lfsr[0];
      repeat (4) @(posedge ref_clk);
      check({gpio_oe, mirror_power_enable_oe, led_driver_on_oe,
        led_select_0_oe, led_select_1_oe, flash_serial_clock_oe,
        flash_serial_out_oe, flash_chip_select_oe, init_busy_out}, 0);
      sys_rst <= 1'b0;
      nbytes = 0;
      repeat (2) @(posedge ref_clk);
      #1 check({init_busy_out, gpio_oe, flash_serial_clock_oe}, 3'h7);
      repeat (run == 1 ? 2600 + lfsr : lfsr) @(posedge ref_clk);
      check({init_busy_out, flash_chip_select}, 2'h3);
      pll_locked <= 1'b1;
      if (run == 2)
      begin
        repeat (2800) @(posedge ref_clk);
        sys_rst <= 1'b1;
        @(posedge ref_clk);
        #1 check({flash_chip_select_oe, init_busy_out}, 0);
      end
      else
      begin
        for (int t = 0; t < 8000 && init_busy_out !== 1'b0; t++)
          @(posedge ref_clk);
        #1 check({nbytes, hdr[39:8]}, {32'h40, 8'h0b, 24'h000000});
        check({gpio_out, flash_chip_select, mirror_power_enable, led_driver_on,
          led_select_0, led_select_1}, {gpio_in, 2'h3, 3'h0});
      end
    end
    report_and_stop();
  end
endmodule : testbench
